/* File: hw/rdf_regs.svh */
// Register offsets, field positions, reset values and counts of the residual differential stage.
// Assumes a plain register port with byte addresses on 32-bit words.
`ifndef RDF_REGS_SVH
`define RDF_REGS_SVH
`define RDF_A_CTRL      8'h00
`define RDF_A_BASE      8'h04
`define RDF_A_TP1       8'h08
`define RDF_A_SL1       8'h0c
`define RDF_A_TP2       8'h10
`define RDF_A_SL2       8'h14
`define RDF_A_STAT      8'h18
`define RDF_A_IST       8'h1c
`define RDF_A_IMASK     8'h20
`define RDF_A_REL       8'h24
`define RDF_A_RSEL      8'h28
`define RDF_A_R_TS      8'h30
`define RDF_A_R_CODE    8'h34
`define RDF_A_R_BIAS    8'h38
`define RDF_A_R_DIFF    8'h3c
`define RDF_A_R_CHR     8'h40
`define RDF_A_R_BMAX    8'h44
`define RDF_A_R_DMAX    8'h48
`define RDF_A_R_CMAX    8'h4c
`define RDF_A_R_CALC    8'h50
`define RDF_A_R_MEAS    8'h54
`define RDF_F_EN        0
`define RDF_F_MSEL      1
`define RDF_F_SUB       2
`define RDF_F_BMAX      3
`define RDF_F_EVON      4
`define RDF_F_EVOFF     5
`define RDF_F_SG_LSB    8
`define RDF_CTRL_RST    32'h0000_0031
`define RDF_BASE_RST    24'h0003e8
`define RDF_TP1_RST     24'h002710
`define RDF_SL1_RST     16'h03e8
`define RDF_TP2_RST     24'h007530
`define RDF_SL2_RST     16'h0fa0
`define RDF_REL_RST     16'h0004
`define RDF_SLOPE_DIV   40'h00_0000_2710
`define RDF_REC_DEPTH   4'hc
`define RDF_REC_LAST    4'hb
`define RDF_EVT_BLOCK   4'h1
`endif

/* File: hw/rdf_pkg.sv */
// Types shared by the residual differential stage.
// Assumes currents in units of 0.01 % of nominal.
package rdf_pkg;
    typedef struct packed {
        logic signed [23:0] re;
        logic signed [23:0] im;
    } rdf_vec_t;
    typedef enum logic [1:0] {
        COND_NORMAL  = 2'b00,
        COND_TRIP    = 2'b01,
        COND_BLOCKED = 2'b10
    } rdf_cond_t;
    typedef enum logic [1:0] {
        EVT_TRIP_ON  = 2'b00,
        EVT_TRIP_OFF = 2'b01,
        EVT_BLK_ON   = 2'b10,
        EVT_BLK_OFF  = 2'b11
    } rdf_evt_code_t;
    typedef struct packed {
        logic [3:0]    block_id;
        rdf_evt_code_t code;
        logic [31:0]   ts;
        logic [23:0]   diff;
        logic [23:0]   bias;
        logic [1:0]    fault;
    } rdf_evt_t;
    typedef struct packed {
        logic [31:0]   ts;
        rdf_evt_code_t code;
        logic [2:0]    sg;
        logic [23:0]   bias;
        logic [23:0]   diff;
        logic [27:0]   chr;
        logic [23:0]   bias_max;
        logic [23:0]   diff_max;
        logic [27:0]   chr_max;
        logic [23:0]   calc;
        logic [23:0]   meas;
    } rdf_rec_t;
endpackage

/* File: hw/rdf_mag.sv */
// Magnitude estimate of one current phasor.
// Assumes inputs registered on core_clk; purely combinational.
`timescale 1ns/1ps
module rdf_mag (
    input  rdf_pkg::rdf_vec_t vec,
    output logic [23:0]       mag
);
    import rdf_pkg::*;
    logic [23:0] abs_re;
    logic [23:0] abs_im;
    logic [23:0] hi_v;
    logic [23:0] lo_v;
    // Max plus 3/8 min: no multiplier, error below about 7 %
    always_comb begin
        abs_re = vec.re[23] ? 24'(-vec.re) : 24'(vec.re);
        abs_im = vec.im[23] ? 24'(-vec.im) : 24'(vec.im);
        hi_v   = (abs_re > abs_im) ? abs_re : abs_im;
        lo_v   = (abs_re > abs_im) ? abs_im : abs_re;
        mag    = hi_v + (lo_v >> 2) + (lo_v >> 3);
    end
endmodule

/* File: hw/rdf_char.sv */
// Biased differential characteristic: threshold versus bias current.
// Assumes settings stable between program cycles; purely combinational.
`timescale 1ns/1ps
`include "rdf_regs.svh"
module rdf_char (
    input  logic [23:0] bias,
    input  logic [23:0] base,
    input  logic [23:0] tp1,
    input  logic [15:0] sl1,
    input  logic [23:0] tp2,
    input  logic [15:0] sl2,
    output logic [27:0] thr
);
    logic [23:0] hi_b;
    logic [23:0] span1;
    logic [23:0] span2;
    logic [39:0] rise1;
    logic [39:0] rise2;
    always_comb begin
        hi_b  = (bias > tp2) ? tp2 : bias;
        span1 = (hi_b > tp1) ? hi_b - tp1 : 24'h0;
        span2 = (bias > tp2) ? bias - tp2 : 24'h0;
        rise1 = (40'(span1) * 40'(sl1)) / `RDF_SLOPE_DIV;
        rise2 = (40'(span2) * 40'(sl2)) / `RDF_SLOPE_DIV;
        thr   = 28'(base) + rise1[27:0] + rise2[27:0];
    end
endmodule

/* File: hw/rdf_stage.sv */
// Residual differential stage: blocking, trip, events and operation records.
// Assumes cyc_tick, block_in and currents come from logic on core_clk, ticks at least 8 cycles apart.
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "rdf_regs.svh"
module rdf_stage (
    input  logic                    core_clk,
    input  logic                    rst,
    input  logic                    cyc_tick,
    input  logic                    block_in,
    input  rdf_pkg::rdf_vec_t [2:0] ph_vec,
    input  rdf_pkg::rdf_vec_t       res1_vec,
    input  rdf_pkg::rdf_vec_t       res2_vec,
    input  logic [31:0]             time_ms,
    input  logic [7:0]              reg_addr,
    input  logic [31:0]             reg_wdata,
    input  logic                    reg_wr,
    input  logic                    reg_rd,
    output logic [31:0]             reg_rdata,
    output logic                    trip,
    output logic                    blocked,
    output logic                    evt_valid,
    output rdf_pkg::rdf_evt_t       evt,
    output logic                    disp_evt,
    output logic                    irq
);
    import rdf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    logic [31:0]        ctrl_ff;
    logic [23:0]        base_ff;
    logic [23:0]        tp1_ff;
    logic [23:0]        tp2_ff;
    logic [15:0]        sl1_ff;
    logic [15:0]        sl2_ff;
    logic [15:0]        rel_ff;
    logic [3:0]         rsel_ff;
    logic [3:0]         ist_ff;
    logic [3:0]         imask_ff;
    logic               blk_smp_ff;
    logic               eval_ff;
    rdf_vec_t [2:0]     ph_smp_ff;
    rdf_vec_t           meas_smp_ff;
    rdf_cond_t          cond_ff;
    rdf_cond_t          nxt_cond;
    logic [15:0]        rel_cnt_ff;
    logic [3:0]         pend_ff;
    logic [3:0]         ev;
    logic [3:0]         ev_sel;
    logic [3:0]         grant;
    logic [23:0]        bias_max_ff;
    logic [23:0]        diff_max_ff;
    logic [27:0]        chr_max_ff;
    rdf_rec_t           rec_mem [12];
    logic [3:0]         wr_ptr_ff;
    logic [3:0]         rec_cnt_ff;
    logic [4:0]         idx_sum;
    logic [3:0]         rd_idx;
    rdf_rec_t           rec_rd;
    rdf_rec_t           rec_new;
    rdf_vec_t [5:0]     mvec;
    logic [23:0]        mag [6];
    logic [24:0]        bias_avg;
    logic [23:0]        bias_mx;
    logic [23:0]        bias;
    logic [27:0]        thr;
    logic               pickup;
    logic [31:0]        rd_mux;
    logic [3:0]         nxt_ist;
    logic               wr_ist;

    ////////////////////////////////////////////////////////////////////////////////
    // Sampling at the start of each program cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            blk_smp_ff  <= 1'b0;
            eval_ff     <= 1'b0;
            ph_smp_ff   <= '0;
            meas_smp_ff <= '0;
        end else begin
            eval_ff <= cyc_tick;
            if (cyc_tick) begin
                blk_smp_ff  <= block_in;
                ph_smp_ff   <= ph_vec;
                meas_smp_ff <= ctrl_ff[`RDF_F_MSEL] ? res2_vec : res1_vec;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Phasors: three phases, computed residual, measured residual, differential
    always_comb begin
        mvec[2:0]  = ph_smp_ff;
        mvec[3].re = 24'(ph_smp_ff[0].re + ph_smp_ff[1].re + ph_smp_ff[2].re);
        mvec[3].im = 24'(ph_smp_ff[0].im + ph_smp_ff[1].im + ph_smp_ff[2].im);
        mvec[4]    = meas_smp_ff;
        if (ctrl_ff[`RDF_F_SUB]) begin
            mvec[5].re = 24'(mvec[3].re - meas_smp_ff.re);
            mvec[5].im = 24'(mvec[3].im - meas_smp_ff.im);
        end else begin
            mvec[5].re = 24'(mvec[3].re + meas_smp_ff.re);
            mvec[5].im = 24'(mvec[3].im + meas_smp_ff.im);
        end
    end

    for (genvar g = 0; g < 6; g++) begin : g_mag
        rdf_mag u_mag (
            .vec (mvec[g]),
            .mag (mag[g])
        );
    end

    always_comb begin
        bias_avg = (25'(mag[3]) + 25'(mag[4])) >> 1;
        bias_mx  = mag[4];
        for (int i = 0; i < 3; i++) begin
            if (mag[i] > bias_mx) bias_mx = mag[i];
        end
        bias = ctrl_ff[`RDF_F_BMAX] ? bias_mx : bias_avg[23:0];
    end

    rdf_char u_char (
        .bias (bias),
        .base (base_ff),
        .tp1  (tp1_ff),
        .sl1  (sl1_ff),
        .tp2  (tp2_ff),
        .sl2  (sl2_ff),
        .thr  (thr)
    );

    assign pickup = ctrl_ff[`RDF_F_EN] && ({4'h0, mag[5]} > thr);

    ////////////////////////////////////////////////////////////////////////////////
    // Stage condition
    always_comb begin
        nxt_cond = cond_ff;
        if (eval_ff) begin
            unique case (cond_ff)
                COND_NORMAL:  if (pickup) nxt_cond = blk_smp_ff ? COND_BLOCKED : COND_TRIP;
                COND_TRIP: begin
                    if (!pickup) nxt_cond = COND_NORMAL;
                    else if (blk_smp_ff) nxt_cond = COND_BLOCKED;
                end
                COND_BLOCKED: begin
                    if (!pickup) nxt_cond = COND_NORMAL;
                    else if (!blk_smp_ff) nxt_cond = COND_TRIP;
                end
                default:      nxt_cond = COND_NORMAL;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cond_ff  <= COND_NORMAL;
            trip     <= 1'b0;
            blocked  <= 1'b0;
            disp_evt <= 1'b0;
        end else begin
            cond_ff  <= nxt_cond;
            trip     <= (nxt_cond == COND_TRIP);
            blocked  <= (nxt_cond == COND_BLOCKED);
            disp_evt <= ev[2];
        end
    end

    // Release timer runs the same way for pick-up drop and for blocking
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rel_cnt_ff <= 16'h0;
        end else if (cond_ff == COND_TRIP && nxt_cond != COND_TRIP) begin
            rel_cnt_ff <= rel_ff;
        end else if (eval_ff && rel_cnt_ff != 16'h0) begin
            rel_cnt_ff <= rel_cnt_ff - 16'h1;
        end
    end

    // Maxima follow only while tripping; a blocked pick-up is not processed
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bias_max_ff <= 24'h0;
            diff_max_ff <= 24'h0;
            chr_max_ff  <= 28'h0;
        end else if (eval_ff && nxt_cond != COND_TRIP) begin
            bias_max_ff <= 24'h0;
            diff_max_ff <= 24'h0;
            chr_max_ff  <= 28'h0;
        end else if (eval_ff) begin
            if (bias > bias_max_ff) bias_max_ff <= bias;
            if (mag[5] > diff_max_ff) diff_max_ff <= mag[5];
            if (thr > chr_max_ff) chr_max_ff <= thr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Events: one pending flag per code, drained lowest code first
    always_comb begin
        ev[0]     = (nxt_cond == COND_TRIP) && (cond_ff != COND_TRIP);
        ev[1]     = (nxt_cond != COND_TRIP) && (cond_ff == COND_TRIP);
        ev[2]     = (nxt_cond == COND_BLOCKED) && (cond_ff != COND_BLOCKED);
        ev[3]     = (nxt_cond != COND_BLOCKED) && (cond_ff == COND_BLOCKED);
        ev_sel[0] = ev[0] && ctrl_ff[`RDF_F_EVON];
        ev_sel[2] = ev[2] && ctrl_ff[`RDF_F_EVON];
        ev_sel[1] = ev[1] && ctrl_ff[`RDF_F_EVOFF];
        ev_sel[3] = ev[3] && ctrl_ff[`RDF_F_EVOFF];
        grant     = pend_ff & (~pend_ff + 4'h1);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pend_ff   <= 4'h0;
            evt_valid <= 1'b0;
            evt       <= '0;
        end else begin
            pend_ff   <= (pend_ff & ~grant) | ev_sel;
            evt_valid <= (pend_ff != 4'h0);
            if (pend_ff != 4'h0) begin
                evt.block_id <= `RDF_EVT_BLOCK;
                evt.code     <= grant[0] ? EVT_TRIP_ON : grant[1] ? EVT_TRIP_OFF :
                                grant[2] ? EVT_BLK_ON : EVT_BLK_OFF;
                evt.ts       <= time_ms;
                evt.diff     <= mag[5];
                evt.bias     <= bias;
                evt.fault    <= {ctrl_ff[`RDF_F_SUB], ctrl_ff[`RDF_F_MSEL]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Operation records, captured on ON events
    always_comb begin
        rec_new.ts       = time_ms;
        rec_new.code     = ev[0] ? EVT_TRIP_ON : EVT_BLK_ON;
        rec_new.sg       = ctrl_ff[`RDF_F_SG_LSB +: 3];
        rec_new.bias     = bias;
        rec_new.diff     = mag[5];
        rec_new.chr      = thr;
        rec_new.bias_max = (bias > bias_max_ff) ? bias : bias_max_ff;
        rec_new.diff_max = (mag[5] > diff_max_ff) ? mag[5] : diff_max_ff;
        rec_new.chr_max  = (thr > chr_max_ff) ? thr : chr_max_ff;
        rec_new.calc     = mag[3];
        rec_new.meas     = mag[4];
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_ff  <= 4'h0;
            rec_cnt_ff <= 4'h0;
        end else if (ev[0] || ev[2]) begin
            wr_ptr_ff  <= (wr_ptr_ff == `RDF_REC_LAST) ? 4'h0 : wr_ptr_ff + 4'h1;
            if (rec_cnt_ff != `RDF_REC_DEPTH) rec_cnt_ff <= rec_cnt_ff + 4'h1;
        end
    end

    // Storage needs no reset; rec_cnt_ff tells which entries are valid
    always_ff @(posedge core_clk) begin
        if (ev[0] || ev[2]) rec_mem[wr_ptr_ff] <= rec_new;
    end

    // Selector 0 is the newest record
    always_comb begin
        idx_sum = {1'b0, wr_ptr_ff} + 5'h0b - {1'b0, rsel_ff};
        rd_idx  = (idx_sum >= 5'h0c) ? 4'(idx_sum - 5'h0c) : idx_sum[3:0];
        rec_rd  = rec_mem[rd_idx];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register port
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_ff  <= `RDF_CTRL_RST;
            base_ff  <= `RDF_BASE_RST;
            tp1_ff   <= `RDF_TP1_RST;
            sl1_ff   <= `RDF_SL1_RST;
            tp2_ff   <= `RDF_TP2_RST;
            sl2_ff   <= `RDF_SL2_RST;
            rel_ff   <= `RDF_REL_RST;
            rsel_ff  <= 4'h0;
            imask_ff <= 4'h0;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `RDF_A_CTRL:  ctrl_ff  <= {21'h0, reg_wdata[10:8], 2'h0, reg_wdata[5:0]};
                `RDF_A_BASE:  base_ff  <= reg_wdata[23:0];
                `RDF_A_TP1:   tp1_ff   <= reg_wdata[23:0];
                `RDF_A_SL1:   sl1_ff   <= reg_wdata[15:0];
                `RDF_A_TP2:   tp2_ff   <= reg_wdata[23:0];
                `RDF_A_SL2:   sl2_ff   <= reg_wdata[15:0];
                `RDF_A_REL:   rel_ff   <= reg_wdata[15:0];
                `RDF_A_IMASK: imask_ff <= reg_wdata[3:0];
                `RDF_A_RSEL:  rsel_ff  <= (reg_wdata[3:0] > `RDF_REC_LAST) ? `RDF_REC_LAST : reg_wdata[3:0];
                default: ;
            endcase
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_comb begin
        wr_ist  = reg_wr && (reg_addr == `RDF_A_IST);
        nxt_ist = (ist_ff & ~(wr_ist ? reg_wdata[3:0] : 4'h0)) | ev;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ist_ff <= 4'h0;
            irq    <= 1'b0;
        end else begin
            ist_ff <= nxt_ist;
            irq    <= (nxt_ist & imask_ff) != 4'h0;
        end
    end

    always_comb begin
        unique case (reg_addr)
            `RDF_A_CTRL:   rd_mux = ctrl_ff;
            `RDF_A_BASE:   rd_mux = {8'h0, base_ff};
            `RDF_A_TP1:    rd_mux = {8'h0, tp1_ff};
            `RDF_A_SL1:    rd_mux = {16'h0, sl1_ff};
            `RDF_A_TP2:    rd_mux = {8'h0, tp2_ff};
            `RDF_A_SL2:    rd_mux = {16'h0, sl2_ff};
            `RDF_A_STAT:   rd_mux = {20'h0, rec_cnt_ff, 4'h0, (rel_cnt_ff != 16'h0), pickup, cond_ff};
            `RDF_A_IST:    rd_mux = {28'h0, ist_ff};
            `RDF_A_IMASK:  rd_mux = {28'h0, imask_ff};
            `RDF_A_REL:    rd_mux = {16'h0, rel_ff};
            `RDF_A_RSEL:   rd_mux = {28'h0, rsel_ff};
            `RDF_A_R_TS:   rd_mux = rec_rd.ts;
            `RDF_A_R_CODE: rd_mux = {27'h0, rec_rd.sg, rec_rd.code};
            `RDF_A_R_BIAS: rd_mux = {8'h0, rec_rd.bias};
            `RDF_A_R_DIFF: rd_mux = {8'h0, rec_rd.diff};
            `RDF_A_R_CHR:  rd_mux = {4'h0, rec_rd.chr};
            `RDF_A_R_BMAX: rd_mux = {8'h0, rec_rd.bias_max};
            `RDF_A_R_DMAX: rd_mux = {8'h0, rec_rd.diff_max};
            `RDF_A_R_CMAX: rd_mux = {4'h0, rec_rd.chr_max};
            `RDF_A_R_CALC: rd_mux = {8'h0, rec_rd.calc};
            `RDF_A_R_MEAS: rd_mux = {8'h0, rec_rd.meas};
            default:       rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) reg_rdata <= 32'h0;
        else reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_eval_normal_pickup;
        eval_ff && cond_ff == COND_NORMAL && pickup;
    endsequence
    property p_sample_hold;
        @(posedge core_clk) disable iff (rst) !cyc_tick |=> blk_smp_ff == $past(blk_smp_ff);
    endproperty
    a_sample_hold: assert property (p_sample_hold) else $error("block sample moved off tick");
    property p_trip_on;
        @(posedge core_clk) disable iff (rst) s_eval_normal_pickup and !blk_smp_ff |=> trip && !blocked;
    endproperty
    a_trip_on: assert property (p_trip_on) else $error("unblocked pick-up gave no trip");
    property p_blk_on;
        @(posedge core_clk) disable iff (rst) s_eval_normal_pickup and blk_smp_ff |=> blocked && !trip && disp_evt;
    endproperty
    a_blk_on: assert property (p_blk_on) else $error("blocked pick-up not shown");
    property p_trip_cleared;
        @(posedge core_clk) disable iff (rst)
            eval_ff && cond_ff == COND_TRIP && pickup && blk_smp_ff && rel_ff != 16'h0
            |=> !trip ##1 rel_cnt_ff == $past(rel_ff, 2);
    endproperty
    a_trip_cleared: assert property (p_trip_cleared) else $error("block did not clear trip");
    property p_on_event;
        @(posedge core_clk) disable iff (rst)
            ev[0] && ctrl_ff[`RDF_F_EVON] |-> ##[1:4] (evt_valid && evt.code == EVT_TRIP_ON && evt.block_id == 4'h1);
    endproperty
    a_on_event: assert property (p_on_event) else $error("trip ON event missing");
    property p_off_drop;
        @(posedge core_clk) disable iff (rst) ev[1] && !ctrl_ff[`RDF_F_EVOFF] && !pend_ff[1] |=> !pend_ff[1];
    endproperty
    a_off_drop: assert property (p_off_drop) else $error("unselected OFF event kept");
    property p_rec_wrap;
        @(posedge core_clk) disable iff (rst) (ev[0] || ev[2]) && wr_ptr_ff == 4'hb |=> wr_ptr_ff == 4'h0;
    endproperty
    a_rec_wrap: assert property (p_rec_wrap) else $error("record store did not wrap");
    property p_status;
        @(posedge core_clk) disable iff (rst) trip |-> cond_ff == COND_TRIP && !blocked;
    endproperty
    a_status: assert property (p_status) else $error("status code disagrees with trip");
    property p_irq;
        @(posedge core_clk) disable iff (rst) (ist_ff & imask_ff) != 4'h0 && !wr_ist |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("unmasked status without interrupt");
endmodule

/* File: verif/rdf_src_model.sv */
// Far side of the stage: blocking matrix and measured currents.
// Assumes bench commands on core_clk; program cycle of 16 clocks.
`timescale 1ns/1ps
module rdf_src_model (
    input  logic                    core_clk,
    input  logic                    rst,
    input  logic                    blk,
    input  logic [23:0]             amp,
    input  logic                    thru,
    output logic                    cyc_tick,
    output logic                    block_in,
    output rdf_pkg::rdf_vec_t [2:0] ph_vec,
    output rdf_pkg::rdf_vec_t       res1_vec,
    output rdf_pkg::rdf_vec_t       res2_vec,
    output logic [31:0]             time_ms
);
    import rdf_pkg::*;
    logic [3:0] div_ff;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_ff <= 4'h0;
            cyc_tick <= 1'b0;
            block_in <= 1'b0;
            time_ms <= 32'h0;
            ph_vec <= '0;
            res1_vec <= '0;
            res2_vec <= '0;
        end else begin
            div_ff <= div_ff + 4'h1;
            cyc_tick <= (div_ff == 4'hf);
            if (div_ff == 4'h8) begin
                // Block settles well ahead of the tick
                block_in <= blk;
                ph_vec[0].re <= amp;
                res1_vec.re <= thru ? -amp : 24'h0;
                time_ms <= time_ms + 32'h1;
            end
            // Unused input toggles so a wrong select shows
            res2_vec.re <= ~res2_vec.re;
        end
    end
endmodule

/* File: verif/test_rdf_stage.sv */
// Bench of rdf_stage: registers, trip and block outcomes, events, records.
// Assumes rdf_src_model as the far side.
`timescale 1ns/1ps
`include "rdf_regs.svh"
module test_rdf_stage;
    import rdf_pkg::*;
    logic           core_clk = 1'b0;
    logic           rst = 1'b1;
    logic           blk = 1'b0, thru = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
    logic [23:0]    amp = 24'h0, a;
    logic [7:0]     reg_addr = 8'h0;
    logic [31:0]    reg_wdata = 32'h0, reg_rdata, time_ms;
    logic           cyc_tick, block_in, trip, blocked, evt_valid, disp_evt, irq;
    logic [1:0]     cond_ff = 2'h0;
    rdf_vec_t [2:0] ph_vec;
    rdf_vec_t       res1_vec, res2_vec;
    rdf_evt_t       evt;
    int             n_mismatch = 0, checks_done = 0, n_disp = 0;
    logic [31:0]    q_rd[$], q_ev[$], q_cd[$];

    always #2 core_clk = ~core_clk;

    rdf_src_model rdf_src_model_inst (.core_clk(core_clk), .rst(rst), .blk(blk), .amp(amp), .thru(thru),
        .cyc_tick(cyc_tick), .block_in(block_in), .ph_vec(ph_vec), .res1_vec(res1_vec),
        .res2_vec(res2_vec), .time_ms(time_ms));
    rdf_stage rdf_stage_inst (.core_clk(core_clk), .rst(rst), .cyc_tick(cyc_tick), .block_in(block_in),
        .ph_vec(ph_vec), .res1_vec(res1_vec), .res2_vec(res2_vec), .time_ms(time_ms),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .trip(trip), .blocked(blocked), .evt_valid(evt_valid), .evt(evt),
        .disp_evt(disp_evt), .irq(irq));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Gap cycle after each strobe keeps one assignment per signal per step
    task automatic reg_write(input logic [7:0] ad, input logic [31:0] d);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic reg_read(input logic [7:0] ad, input logic [31:0] e);
        q_rd.push_back(e);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic ev(input logic [23:0] d, input rdf_evt_code_t c);
        q_ev.push_back({d, `RDF_EVT_BLOCK, 2'h0, c});
    endtask

    task automatic cd(input logic [1:0] c);
        q_cd.push_back({30'h0, c});
    endtask

    task automatic step(input logic b, input logic [23:0] f, input logic t);
        int k;
        blk <= b;
        amp <= f;
        thru <= t;
        repeat (40) @(posedge core_clk);
        for (k = 0; k < 200 && (q_ev.size() || q_cd.size()); k++)
            @(posedge core_clk);
        if (k == 200) begin
            n_mismatch++;
            finish_test();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        if (!rst) begin
            rd_d <= reg_rd;
            if (rd_d)
                check(reg_rdata, q_rd.size() ? q_rd.pop_front() : 'x);
            if (evt_valid === 1'b1) begin
                check({evt.diff, evt.block_id, evt.fault, evt.code}, q_ev.size() ? q_ev.pop_front() : 'x);
                check(evt.ts, time_ms);
            end
            if ({trip, blocked} !== cond_ff) begin
                cond_ff <= {trip, blocked};
                check({30'h0, trip, blocked}, q_cd.size() ? q_cd.pop_front() : 'x);
            end
            n_disp += (disp_evt === 1'b1);
        end
    end

    initial begin
        int i;
        void'($urandom(37));
        a = 24'h7d0 + 24'($urandom % 4000);
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        reg_read(`RDF_A_CTRL, `RDF_CTRL_RST);
        reg_read(8'hfc, 32'h0);
        reg_write(`RDF_A_IMASK, 32'h1);
        step(1'b0, a, 1'b1);
        cd(2'h2);
        ev(a, EVT_TRIP_ON);
        step(1'b0, a, 1'b0);
        check(irq, 1'b1);
        reg_write(`RDF_A_IST, 32'hf);
        @(posedge core_clk);
        #1 check(irq, 1'b0);
        cd(2'h1);
        ev(a, EVT_TRIP_OFF);
        ev(a, EVT_BLK_ON);
        step(1'b1, a, 1'b0);
        cd(2'h0);
        ev(24'h0, EVT_BLK_OFF);
        step(1'b1, 24'h0, 1'b0);
        cd(2'h1);
        ev(a, EVT_BLK_ON);
        step(1'b1, a, 1'b0);
        cd(2'h0);
        ev(24'h0, EVT_BLK_OFF);
        step(1'b0, 24'h0, 1'b0);
        reg_write(`RDF_A_CTRL, 32'h11);
        for (i = 0; i < 10; i++) begin
            cd(2'h2);
            ev(a, EVT_TRIP_ON);
            step(1'b0, a, 1'b0);
            cd(2'h0);
            step(1'b0, 24'h0, 1'b0);
        end
        // Subtract mode: a through current now doubles the differential
        reg_write(`RDF_A_CTRL, 32'h15);
        cd(2'h2);
        q_ev.push_back({a + a, `RDF_EVT_BLOCK, 2'h2, EVT_TRIP_ON});
        step(1'b0, a, 1'b1);
        cd(2'h0);
        step(1'b0, 24'h0, 1'b0);
        repeat (80) @(posedge core_clk);
        reg_read(`RDF_A_STAT, 32'h0000_0c00);
        reg_read(`RDF_A_R_DIFF, {8'h0, a + a});
        reg_read(`RDF_A_R_BIAS, {8'h0, a});
        reg_write(`RDF_A_RSEL, 32'hf);
        reg_read(`RDF_A_R_CODE, 32'h2);
        repeat (4) @(posedge core_clk);
        check(n_disp, 32'h2);
        finish_test();
    end
endmodule
